// *** aleu_map.svh ***
// Constant map for the add/logic execute unit
`ifndef ALEU_MAP_SVH
`define ALEU_MAP_SVH

// Field start positions, bit 0 is the word's most significant bit
`define ALEU_OPC_POS      0
`define ALEU_RD_POS       6
`define ALEU_RA_POS       11
`define ALEU_RB_POS       16
`define ALEU_TAIL_POS     21
`define ALEU_LIT_POS      16
`define ALEU_KEEP_POS     3
`define ALEU_CIN_POS      4

// Field widths
`define ALEU_OPC_W        6
`define ALEU_REG_W        5
`define ALEU_LIT_W        16
`define ALEU_WORD_W       32

// Opcodes; the keep and carry-in bits are masked before compare of the add opcodes only
`define ALEU_OPC_ADD      6'h00
`define ALEU_OPC_ADDI     6'h08
`define ALEU_OPC_KC_MASK  6'h06
`define ALEU_OPC_AND      6'h21
`define ALEU_OPC_ANDI     6'h29
`define ALEU_OPC_PREFIX   6'h2c

// Register port map
`define ALEU_ADDR_W       6
`define ALEU_ADDR_STATUS  6'h20
`define ALEU_STATUS_CARRY 0

// Reset values
`define ALEU_RST_CARRY    1'b0
`define ALEU_RST_WORD     32'h00000000
`define ALEU_RST_LIT      16'h0000

`endif

// *** aleu_pkg.sv ***
// Types shared by the add/logic execute unit
package aleu_pkg;

  typedef enum logic [2:0] {
    CLS_NONE   = 3'h0,
    CLS_ADD    = 3'h1,
    CLS_AND    = 3'h2,
    CLS_PREFIX = 3'h3,
    CLS_TRAP   = 3'h4,
    CLS_OTHER  = 3'h5
  } aleu_class_t;

  typedef struct packed {
    aleu_class_t cls;
    logic        isImm;
    logic        keepCarry;
    logic        useCarry;
    logic [4:0]  dest;
    logic [15:0] lit;
  } aleu_dec_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } aleu_result_t;

endpackage

// *** aleu_regfile.sv ***
// General register file with registered, write-through read ports
`timescale 1ns/1ps
module aleu_regfile #(
  parameter int WIDTH    = 32,
  parameter int ADDR_W   = 5,
  parameter int RD_PORTS = 3
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              wrEn,
  input  wire logic [ADDR_W-1:0]                 wrAddr,
  input  wire logic [WIDTH-1:0]                  wrData,
  input  wire logic [RD_PORTS-1:0][ADDR_W-1:0]   rdAddr,
  output logic      [RD_PORTS-1:0][WIDTH-1:0]    rdData
);

  logic [WIDTH-1:0] mem [1:(1<<ADDR_W)-1];

  // Register zero is constant zero; writes to it are dropped
  always_ff @(posedge clk) begin
    if (wrEn && (wrAddr != '0)) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Same-edge write is passed through so back-to-back use sees it
  for (genvar p = 0; p < RD_PORTS; p++) begin : g_rd
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rdData[p] <= '0;
      end else if (rdAddr[p] == '0) begin
        rdData[p] <= '0;
      end else if (wrEn && (wrAddr == rdAddr[p])) begin
        rdData[p] <= wrData;
      end else begin
        rdData[p] <= mem[rdAddr[p]];
      end
    end
  end

endmodule

// *** aleu_exec.sv ***
// Decode and execute of the add family, and, and-immediate
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "aleu_map.svh"
module aleu_exec (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        instrValid,
  input  wire logic [`ALEU_WORD_W-1:0]     instrWord,
  input  wire logic                        zeroWordIllegalOption,
  input  wire logic [`ALEU_ADDR_W-1:0]     regAddr,
  input  wire logic [`ALEU_WORD_W-1:0]     regWrData,
  input  wire logic                        regWrStb,
  input  wire logic                        regRdStb,
  output logic      [`ALEU_WORD_W-1:0]     regRdData,
  output aleu_pkg::aleu_result_t           result,
  output logic                             carryFlagBit,
  output logic                             illegalInstr,
  output logic                             unhandledInstr,
  output logic                             prefixPending
);

  localparam int OPC_MSB  = `ALEU_WORD_W - 1 - `ALEU_OPC_POS;
  localparam int RD_MSB   = `ALEU_WORD_W - 1 - `ALEU_RD_POS;
  localparam int RA_MSB   = `ALEU_WORD_W - 1 - `ALEU_RA_POS;
  localparam int RB_MSB   = `ALEU_WORD_W - 1 - `ALEU_RB_POS;
  localparam int LIT_MSB  = `ALEU_WORD_W - 1 - `ALEU_LIT_POS;
  localparam int KEEP_IDX = `ALEU_WORD_W - 1 - `ALEU_KEEP_POS;
  localparam int CIN_IDX  = `ALEU_WORD_W - 1 - `ALEU_CIN_POS;

  // Issue stage: instruction held while operands are read
  logic                     issueValid_reg;
  logic [`ALEU_WORD_W-1:0]  issueWord_reg;
  logic                     zeroOpt_reg;

  // Machine status carry and immediate prefix state
  logic                     carry_reg;
  logic                     carry_next;
  logic                     prefixValid_reg;
  logic [`ALEU_LIT_W-1:0]   prefixHi_reg;

  // Register port read tracking
  logic                     rdPending_reg;
  logic                     rdStatus_reg;

  // Register file wiring
  logic [2:0][`ALEU_REG_W-1:0]   rfRdAddr;
  logic [2:0][`ALEU_WORD_W-1:0]  rfRdData;
  logic                          rfWrEn;
  logic [`ALEU_REG_W-1:0]        rfWrAddr;
  logic [`ALEU_WORD_W-1:0]       rfWrData;

  // Execute stage signals
  aleu_pkg::aleu_dec_t           dec;
  logic [`ALEU_WORD_W-1:0]       opA;
  logic [`ALEU_WORD_W-1:0]       litExt;
  logic [`ALEU_WORD_W-1:0]       opB;
  logic [`ALEU_WORD_W:0]         sum;
  logic                          carryIn;
  logic                          execWr;
  logic [`ALEU_WORD_W-1:0]       execData;

  // Instruction decode
  function automatic aleu_pkg::aleu_dec_t decode(input logic [`ALEU_WORD_W-1:0] w, input logic zeroOpt);
    aleu_pkg::aleu_dec_t d;
    logic [`ALEU_OPC_W-1:0] opc;
    logic [`ALEU_OPC_W-1:0] base;
    opc         = w[OPC_MSB -: `ALEU_OPC_W];
    base        = opc & ~`ALEU_OPC_KC_MASK;
    d.dest      = w[RD_MSB -: `ALEU_REG_W];
    d.lit       = w[LIT_MSB -: `ALEU_LIT_W];
    d.keepCarry = w[KEEP_IDX];
    d.useCarry  = w[CIN_IDX];
    d.isImm     = 1'b0;
    d.cls       = aleu_pkg::CLS_OTHER;
    if (zeroOpt && (w == `ALEU_RST_WORD)) begin
      d.cls = aleu_pkg::CLS_TRAP;
    end else if (base == `ALEU_OPC_ADD) begin
      d.cls = aleu_pkg::CLS_ADD;
    end else if (base == `ALEU_OPC_ADDI) begin
      d.cls   = aleu_pkg::CLS_ADD;
      d.isImm = 1'b1;
    end else if (opc == `ALEU_OPC_AND) begin
      d.cls = aleu_pkg::CLS_AND;
    end else if (opc == `ALEU_OPC_ANDI) begin
      d.cls   = aleu_pkg::CLS_AND;
      d.isImm = 1'b1;
    end else if (opc == `ALEU_OPC_PREFIX) begin
      d.cls = aleu_pkg::CLS_PREFIX;
    end
    return d;
  endfunction

  // Port 0 and 1 feed the instruction, port 2 serves the register port
  always_comb begin
    rfRdAddr[0] = instrWord[RA_MSB -: `ALEU_REG_W];
    rfRdAddr[1] = instrWord[RB_MSB -: `ALEU_REG_W];
    rfRdAddr[2] = regAddr[`ALEU_REG_W-1:0];
  end

  aleu_regfile #(
    .WIDTH    (`ALEU_WORD_W),
    .ADDR_W   (`ALEU_REG_W),
    .RD_PORTS (3)
  ) u_regfile (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wrEn    (rfWrEn),
    .wrAddr  (rfWrAddr),
    .wrData  (rfWrData),
    .rdAddr  (rfRdAddr),
    .rdData  (rfRdData)
  );

  // Issue stage capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      issueValid_reg <= 1'b0;
      issueWord_reg  <= `ALEU_RST_WORD;
      zeroOpt_reg    <= 1'b0;
    end else begin
      issueValid_reg <= instrValid;
      zeroOpt_reg    <= zeroWordIllegalOption;
      if (instrValid) begin
        issueWord_reg <= instrWord;
      end
    end
  end

  assign dec = decode(issueWord_reg, zeroOpt_reg);

  // Operand selection
  always_comb begin
    opA     = rfRdData[0];
    litExt  = prefixValid_reg ? {prefixHi_reg, dec.lit}
                              : {{(`ALEU_WORD_W-`ALEU_LIT_W){dec.lit[`ALEU_LIT_W-1]}}, dec.lit};
    opB     = dec.isImm ? litExt : rfRdData[1];
    carryIn = dec.useCarry & carry_reg;
  end

  assign sum = {1'b0, opA} + {1'b0, opB} + {{`ALEU_WORD_W{1'b0}}, carryIn};

  // Result and write decision
  always_comb begin
    execWr   = 1'b0;
    execData = sum[`ALEU_WORD_W-1:0];
    if (issueValid_reg) begin
      unique case (dec.cls)
        aleu_pkg::CLS_ADD: begin
          execWr   = 1'b1;
          execData = sum[`ALEU_WORD_W-1:0];
        end
        aleu_pkg::CLS_AND: begin
          execWr   = 1'b1;
          execData = opA & opB;
        end
        aleu_pkg::CLS_NONE,
        aleu_pkg::CLS_PREFIX,
        aleu_pkg::CLS_TRAP,
        aleu_pkg::CLS_OTHER: begin
          execWr = 1'b0;
        end
        default: begin
          execWr = 1'b0;
        end
      endcase
    end
  end

  // Execute write wins over a register-port write in the same cycle
  always_comb begin
    if (execWr) begin
      rfWrEn   = 1'b1;
      rfWrAddr = dec.dest;
      rfWrData = execData;
    end else begin
      rfWrEn   = regWrStb && (regAddr[`ALEU_ADDR_W-1] == 1'b0);
      rfWrAddr = regAddr[`ALEU_REG_W-1:0];
      rfWrData = regWrData;
    end
  end

  // Carry update: instruction effect beats a register-port write
  always_comb begin
    carry_next = carry_reg;
    if (regWrStb && (regAddr == `ALEU_ADDR_STATUS)) begin
      carry_next = regWrData[`ALEU_STATUS_CARRY];
    end
    if (issueValid_reg && (dec.cls == aleu_pkg::CLS_ADD) && !dec.keepCarry) begin
      carry_next = sum[`ALEU_WORD_W];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      carry_reg <= `ALEU_RST_CARRY;
    end else begin
      carry_reg <= carry_next;
    end
  end

  // Prefix lasts for exactly the next executed instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prefixValid_reg <= 1'b0;
      prefixHi_reg    <= `ALEU_RST_LIT;
    end else if (issueValid_reg) begin
      if (dec.cls == aleu_pkg::CLS_PREFIX) begin
        prefixValid_reg <= 1'b1;
        prefixHi_reg    <= dec.lit;
      end else begin
        prefixValid_reg <= 1'b0;
      end
    end
  end

  // Result and event outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result         <= '0;
      illegalInstr   <= 1'b0;
      unhandledInstr <= 1'b0;
    end else begin
      result.valid   <= execWr;
      illegalInstr   <= issueValid_reg && (dec.cls == aleu_pkg::CLS_TRAP);
      unhandledInstr <= issueValid_reg && (dec.cls == aleu_pkg::CLS_OTHER);
      if (execWr) begin
        result.dest <= dec.dest;
        result.data <= execData;
      end
    end
  end

  // Register port read: data stands in the next cycle only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPending_reg <= 1'b0;
      rdStatus_reg  <= 1'b0;
    end else begin
      rdPending_reg <= regRdStb && (regAddr[`ALEU_ADDR_W-1] == 1'b0);
      rdStatus_reg  <= regRdStb && (regAddr == `ALEU_ADDR_STATUS);
    end
  end

  always_comb begin
    regRdData = '0;
    if (rdStatus_reg) begin
      regRdData[`ALEU_STATUS_CARRY] = carry_reg;
    end else if (rdPending_reg) begin
      regRdData = rfRdData[2];
    end
  end

  assign carryFlagBit  = carry_reg;
  assign prefixPending = prefixValid_reg;

endmodule

// *** aleu_exec_asserts.sv ***
// Port-level assertions for the add/logic execute unit
`timescale 1ns/1ps
`include "aleu_map.svh"
module aleu_exec_asserts (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic                   instrValid,
  input wire logic [31:0]            instrWord,
  input wire logic                   zeroWordIllegalOption,
  input wire logic                   regRdStb,
  input wire logic [31:0]            regRdData,
  input wire aleu_pkg::aleu_result_t result,
  input wire logic                   carryFlagBit,
  input wire logic                   illegalInstr,
  input wire logic                   unhandledInstr,
  input wire logic                   prefixPending
);
  logic [5:0] opc, base;
  logic [4:0] dst;
  logic       trap, isAdd, isAnd, isPre;
  assign opc   = instrWord[31:26];
  assign base  = opc & ~`ALEU_OPC_KC_MASK;
  assign dst   = instrWord[25:21];
  assign trap  = instrWord == 32'h0 && zeroWordIllegalOption;
  assign isAdd = !trap && (base == `ALEU_OPC_ADD || base == `ALEU_OPC_ADDI);
  assign isAnd = opc == `ALEU_OPC_AND || opc == `ALEU_OPC_ANDI;
  assign isPre = opc == `ALEU_OPC_PREFIX;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_add;
    instrValid && isAdd;
  endsequence
  sequence s_wrote;
    ##2 result.valid && result.dest == $past(dst, 2);
  endsequence
  property p_addWrite; (s_add ##0 dst != 5'h0) |-> s_wrote; endproperty
  property p_keep; (s_add ##0 instrWord[28]) |-> ##2 $stable(carryFlagBit); endproperty
  property p_and; instrValid && isAnd && dst != 5'h0 |-> s_wrote ##0 $stable(carryFlagBit); endproperty
  property p_trap; instrValid && trap |-> ##2 illegalInstr && !result.valid; endproperty
  property p_other;
    instrValid && !trap && !isAdd && !isAnd && !isPre |-> ##2 unhandledInstr && !result.valid;
  endproperty
  property p_prefix; instrValid && isPre |-> ##[1:2] prefixPending; endproperty
  property p_rdIdle; !$past(regRdStb) |-> regRdData == 32'h0; endproperty
  property p_reset;
    disable iff (1'b0) $fell(sys_rst) |-> !carryFlagBit && !prefixPending && !result.valid;
  endproperty
  a_addWrite: assert property (p_addWrite) else $error("add gave no write");
  a_keep: assert property (p_keep) else $error("kept carry moved");
  a_and: assert property (p_and) else $error("and write or carry wrong");
  a_trap: assert property (p_trap) else $error("zero word not trapped");
  a_other: assert property (p_other) else $error("other opcode not flagged");
  a_prefix: assert property (p_prefix) else $error("prefix not pending");
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule
bind aleu_exec aleu_exec_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid),
  .instrWord(instrWord), .zeroWordIllegalOption(zeroWordIllegalOption), .regRdStb(regRdStb),
  .regRdData(regRdData), .result(result), .carryFlagBit(carryFlagBit), .illegalInstr(illegalInstr),
  .unhandledInstr(unhandledInstr), .prefixPending(prefixPending));

// *** aleu_fetch_model.sv ***
// Fetch-side model offering instruction words to the execute unit
`timescale 1ns/1ps
module aleu_fetch_model (
  input wire logic   clk,
  output logic        instrValid,
  output logic [31:0] instrWord
);
  initial begin
    instrValid = 1'b0;
    instrWord = 32'h0;
  end
  // Released word is inverted so a stale value is never trusted
  task automatic issue(input logic [31:0] w, input logic last);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    if (last) begin
      @(posedge clk);
      instrValid <= 1'b0;
      instrWord <= ~w;
    end
  endtask
endmodule

// *** aleu_exec_test.sv ***
// Self-checking bench for the add/logic execute unit
`timescale 1ns/1ps
`include "aleu_map.svh"
module aleu_exec_test;
  logic                   clk, sys_rst, zeroWordIllegalOption, regWrStb, regRdStb, instrValid;
  logic                   carryFlagBit, illegalInstr, unhandledInstr, prefixPending;
  logic [31:0]            instrWord, regWrData, regRdData;
  logic [5:0]             regAddr;
  aleu_pkg::aleu_result_t result;
  int                     nErrors = 0;
  int                     numChecks = 0;
  aleu_exec dut (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord),
    .zeroWordIllegalOption(zeroWordIllegalOption), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .result(result),
    .carryFlagBit(carryFlagBit), .illegalInstr(illegalInstr), .unhandledInstr(unhandledInstr),
    .prefixPending(prefixPending));
  aleu_fetch_model fetch (.clk(clk), .instrValid(instrValid), .instrWord(instrWord));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  function automatic logic [31:0] enc(input logic [5:0] o, input logic [4:0] d, input logic [4:0] a,
                                      input logic [15:0] l);
    return {o, d, a, l};
  endfunction
  // Result is visible one edge after the word is taken
  task automatic run(input logic [31:0] w);
    fetch.issue(w, 1'b1);
    @(posedge clk);
    #1;
  endtask
  task automatic res(input logic [4:0] d, input logic [31:0] v);
    chk({31'h0, result.valid}, 32'h1);
    chk({27'h0, result.dest}, {27'h0, d});
    chk(result.data, v);
  endtask
  task automatic t_regs;
    wr(6'h1, 32'h00007fff);
    wr(6'h2, 32'hffff8000);
    wr(6'h5, 32'h12345678);
    wr(6'h0, 32'h5);
    rd(6'h2, 32'hffff8000);
    rd(6'h0, 32'h0);
    rd(6'h21, 32'h0);
    wr(`ALEU_ADDR_STATUS, 32'h1);
    rd(`ALEU_ADDR_STATUS, 32'h1);
    $display("regs ok");
  endtask
  // All four carry variants in both formats
  task automatic t_add;
    logic [32:0] s;
    logic [5:0]  o;
    for (int k = 0; k < 8; k++) begin
      wr(`ALEU_ADDR_STATUS, 32'h1);
      o = (k[2] ? `ALEU_OPC_ADDI : `ALEU_OPC_ADD) | {3'h0, k[1], k[0], 1'b0};
      run(enc(o, 5'h3, 5'h1, k[2] ? 16'h8000 : 16'h1000));
      s = {1'b0, 32'h00007fff} + {1'b0, 32'hffff8000} + {32'h0, k[0]};
      res(5'h3, s[31:0]);
      chk({31'h0, carryFlagBit}, {31'h0, k[1] ? 1'b1 : s[32]});
      rd(6'h3, s[31:0]);
    end
    $display("add ok");
  endtask
  task automatic t_logic;
    run(enc(`ALEU_OPC_AND, 5'h4, 5'h5, 16'h1000));
    res(5'h4, 32'h12340000);
    run(enc(`ALEU_OPC_ANDI, 5'h4, 5'h5, 16'hf00f));
    res(5'h4, 32'h12345008);
    run(enc(`ALEU_OPC_ANDI, 5'h4, 5'h5, 16'h0ff0));
    res(5'h4, 32'h00000670);
    chk({31'h0, carryFlagBit}, 32'h1);
    run(enc(`ALEU_OPC_PREFIX, 5'h0, 5'h0, 16'habcd));
    chk({31'h0, prefixPending}, 32'h1);
    run(enc(`ALEU_OPC_ADDI | 6'h04, 5'h6, 5'h1, 16'h0001));
    res(5'h6, 32'habcd8000);
    run(enc(`ALEU_OPC_ADDI | 6'h04, 5'h6, 5'h1, 16'h0001));
    res(5'h6, 32'h00008000);
    $display("logic ok");
  endtask
  task automatic t_odd;
    @(posedge clk);
    zeroWordIllegalOption <= 1'b1;
    run(32'h0);
    chk({30'h0, illegalInstr, result.valid}, 32'h2);
    @(posedge clk);
    zeroWordIllegalOption <= 1'b0;
    run(32'h0);
    chk({30'h0, illegalInstr, carryFlagBit}, 32'h0);
    run(enc(6'h3f, 5'h3, 5'h1, 16'h0));
    chk({30'h0, unhandledInstr, result.valid}, 32'h2);
    // Carry is clear here, so the carry-in form must add nothing
    fetch.issue(enc(`ALEU_OPC_ADD | 6'h02, 5'h7, 5'h1, 16'h1000), 1'b0);
    fetch.issue(enc(`ALEU_OPC_ADD, 5'h8, 5'h7, 16'h3800), 1'b1);
    @(posedge clk);
    #1;
    res(5'h8, 32'hfffffffe);
    chk({31'h0, carryFlagBit}, 32'h1);
    $display("odd ok");
  endtask
  initial begin
    sys_rst = 1'b1;
    zeroWordIllegalOption = 1'b0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 6'h0;
    regWrData = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_add;
    t_logic;
    t_odd;
    report_and_stop;
  end
  initial begin
    #100000;
    nErrors++;
    report_and_stop;
  end
endmodule
